/* src/asp_link_if.sv */
// Sampled serial link events passed from the front end to the core
`timescale 1ns/1ps
interface asp_link_if;
    logic rise;
    logic fall;
    logic bit_in;
    logic cs_act;
    logic soft_rst;
    modport src (output rise, fall, bit_in, cs_act, soft_rst);
    modport dst (input rise, fall, bit_in, cs_act, soft_rst);
endinterface

/* src/asp_link_sync.sv */
// Pin synchronisers, serial clock edge finder and ones counter
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_link_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    asp_link_if.src lk
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [2:0] sclk_ff;
    logic [1:0] din_ff;
    logic [1:0] cs_n_ff;
    logic [6:0] ones_ff;
    logic soft_ff;

    // Two stages per pin; third sclk stage only feeds edge detect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_ff <= 3'h7;
            din_ff <= 2'h0;
            cs_n_ff <= 2'h3;
        end else begin
            sclk_ff <= {sclk_ff[1:0], sclk};
            din_ff <= {din_ff[0], din};
            cs_n_ff <= {cs_n_ff[0], cs_n};
        end
    end

    // Mode 3: sample on rising, drive on falling
    assign lk.rise = sclk_ff[1] & ~sclk_ff[2];
    assign lk.fall = ~sclk_ff[1] & sclk_ff[2];
    assign lk.bit_in = din_ff[1];
    assign lk.cs_act = ~cs_n_ff[1];
    assign lk.soft_rst = soft_ff;

    // Ones in a row; a zero or a raised select starts over
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ones_ff <= 7'h00;
            soft_ff <= 1'b0;
        end else begin
            soft_ff <= 1'b0;
            if (!lk.cs_act) begin
                ones_ff <= 7'h00;
            end else if (lk.rise) begin
                if (!lk.bit_in) begin
                    ones_ff <= 7'h00;
                end else if (ones_ff == `ASP_ONES_RESET - 7'h01) begin
                    ones_ff <= 7'h00;
                    soft_ff <= 1'b1;
                end else begin
                    ones_ff <= ones_ff + 7'h01;
                end
            end
        end
    end

    ones_reset_a: assert property (
        lk.rise && lk.bit_in && lk.cs_act &&
        ones_ff == `ASP_ONES_RESET - 7'h01 |=> soft_ff)
        else $error("64 ones did not raise the device reset");
endmodule

/* src/asp_params.svh */
// Constants of the serial register port: offsets, resets, timing
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
// Register indices
`define ASP_A_STATUS 6'h00
`define ASP_A_CTRL 6'h01
`define ASP_A_IO 6'h03
`define ASP_A_ID 6'h05
`define ASP_A_ERREN 6'h07
`define ASP_A_CH0 6'h09
`define ASP_A_CFG0 6'h19
`define ASP_NCH 16
`define ASP_NCFG 8
// Command byte fields
`define ASP_CMD_WEN 7
`define ASP_CMD_RD 6
// Channel register fields
`define ASP_CH_EN 15
// Control register mode field and its continuous code
`define ASP_MODE_LSB 2
`define ASP_MODE_CONT 4'h0
// Reset values
`define ASP_RST_CH0 16'h8001
`define ASP_RST_CH 16'h0001
`define ASP_RST_CFG 16'h0800
`define ASP_RST_CTRL 16'h0000
`define ASP_RST_IO 24'h00_0000
`define ASP_RST_ERREN 24'h00_0040
// Data phase lengths in bits
`define ASP_LEN8 6'h08
`define ASP_LEN16 6'h10
`define ASP_LEN24 6'h18
`define ASP_CMD_LAST 5'h07
// Ones in a row that reset the whole device
`define ASP_ONES_RESET 7'h40
// Clock cycles per conversion slot of the sequencer
`define ASP_CONV_CYCLES 1024
// Arbitrary identity value, names no real part
`define ASP_PART_ID 8'h30
`endif

/* src/asp_pkg.sv */
// Types shared by the serial register port modules
package asp_pkg;
    typedef enum logic [1:0] {
        ASP_ST_CMD,
        ASP_ST_WR,
        ASP_ST_RD
    } asp_state_t;
    typedef logic [5:0] asp_addr_t;
endpackage

/* src/asp_sequencer.sv */
// Channel sequencer: steps through enabled channels in rising order
`timescale 1ns/1ps
module asp_sequencer #(
    parameter int NCH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic srst,
    input wire logic step,
    input wire logic [NCH-1:0] mask,
    output logic [3:0] chan_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // First enabled channel after cur, wrapping; cur if none
    function automatic logic [3:0] next_chan(
        input logic [NCH-1:0] m, input logic [3:0] cur);
        logic [3:0] idx;
        logic found;
        next_chan = cur;
        found = 1'b0;
        for (int i = 1; i <= NCH; i++) begin
            idx = 4'(int'(cur) + i);
            if (!found && m[idx]) begin
                next_chan = idx;
                found = 1'b1;
            end
        end
    endfunction

    // Reset lands on channel zero, the only one enabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_ff <= 4'h0;
        end else if (srst) begin
            chan_ff <= 4'h0;
        end else if (step) begin
            chan_ff <= next_chan(mask, chan_ff);
        end
    end

    // New channel must be enabled, unless the mask moved meanwhile
    seq_skip_a: assert property (
        step && !srst && |mask |=> mask[chan_ff] || $changed(mask))
        else $error("sequencer landed on a disabled channel");
    seq_order_a: assert property (
        step && !srst && mask[4'(chan_ff + 4'h1)]
        |=> chan_ff == 4'($past(chan_ff) + 4'h1))
        else $error("sequencer left ascending order");
endmodule

/* src/asp_serial_port.sv */
// Serial register port of the converter: command, registers, sequencer
//
// Notes on behaviour
// - Mode 3: drive falling edge, sample rising
// - Works with select tied low, counting bits
// - Command byte is write only
// - After reset, first expect a command byte
// - Command low six bits address the register
// - Command chooses read or write phase
// - After data phase, expect a command again
// - 64 ones in a row reset everything
// - Raising select aborts, keeps register contents
// - Write phase is 8, 16 or 24 bits
// - Read phase length set by the register
// - Identity register at 0x05, read only
// - Reset: only channel 0, inputs 0/1, setup 0
// - Reset setup: no buffers, gain 1, external ref
// - Reset control: low power, continuous, internal clock
// - Reset diagnostics: only ignored-write flag enabled
// - Sixteen channels, eight setups, free pairing
// - Channel holds enable, setup and input pair
// - Sequencer visits channels 0 to 15, wraps
// - Sequencer skips disabled channels
// - Four general outputs driven from a register
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_serial_port
    import asp_pkg::*;
#(
    parameter int CONV_CYCLES = `ASP_CONV_CYCLES,
    parameter logic [7:0] PART_ID = `ASP_PART_ID
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic [3:0] gpio,
    output logic [3:0] active_chan
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    asp_link_if lk ();
    asp_state_t st_ff;
    logic [4:0] cnt_ff;
    logic [7:0] cmd_ff;
    asp_addr_t addr_ff;
    logic [5:0] len_ff;
    logic [23:0] wr_sh_ff;
    logic [31:0] rd_sh_ff;
    logic dout_ff;
    logic dout_oe_ff;
    logic [15:0] ch_ff [`ASP_NCH];
    logic [15:0] cfg_ff [`ASP_NCFG];
    logic [15:0] ctrl_ff;
    logic [23:0] io_ff;
    logic [23:0] erren_ff;
    logic [31:0] tick_ff;
    logic [7:0] nxt_cmd;
    logic [23:0] nxt_wr;
    logic [23:0] rd_word;
    logic [5:0] cmd_len;
    logic cmd_done;
    logic last_bit;
    logic [`ASP_NCH-1:0] en_mask;
    logic seq_step;

    asp_link_sync u_link (
        .clk(clk),
        .rst_n(rst_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .din(din),
        .lk(lk)
    );

    // True when the address falls in the block of n registers from base, else false
    function automatic logic in_blk(input asp_addr_t a,
        input asp_addr_t base, input int n);
        in_blk = (a >= base) && (int'(a) < int'(base) + n);
    endfunction

    // Data phase length for an address; unmapped answers 8 bits
    function automatic logic [5:0] reg_len(input asp_addr_t a);
        if (a == `ASP_A_IO || a == `ASP_A_ERREN) begin
            reg_len = `ASP_LEN24;
        end else if (a == `ASP_A_CTRL || in_blk(a, `ASP_A_CH0, `ASP_NCH)
            || in_blk(a, `ASP_A_CFG0, `ASP_NCFG)) begin
            reg_len = `ASP_LEN16;
        end else begin
            reg_len = `ASP_LEN8;
        end
    endfunction

    // Incoming bits, MSB first
    assign nxt_cmd = {cmd_ff[6:0], lk.bit_in};
    assign nxt_wr = {wr_sh_ff[22:0], lk.bit_in};
    assign cmd_done = lk.rise && st_ff == ASP_ST_CMD
        && cnt_ff == `ASP_CMD_LAST;
    assign last_bit = lk.rise && st_ff != ASP_ST_CMD
        && {1'b0, cnt_ff} == len_ff - 6'h01;
    assign cmd_len = reg_len(nxt_cmd[5:0]);

    // Read value of the register being addressed; command not readable
    always_comb begin
        rd_word = 24'h00_0000;
        if (in_blk(nxt_cmd[5:0], `ASP_A_CH0, `ASP_NCH)) begin
            rd_word = {8'h00, ch_ff[4'(nxt_cmd[5:0] - `ASP_A_CH0)]};
        end else if (in_blk(nxt_cmd[5:0], `ASP_A_CFG0, `ASP_NCFG)) begin
            rd_word = {8'h00, cfg_ff[3'(nxt_cmd[5:0] - `ASP_A_CFG0)]};
        end else begin
            unique case (nxt_cmd[5:0])
                `ASP_A_STATUS: rd_word = {20'h0_0000, active_chan};
                `ASP_A_CTRL: rd_word = {8'h00, ctrl_ff};
                `ASP_A_IO: rd_word = io_ff;
                `ASP_A_ID: rd_word = {16'h0000, PART_ID};
                `ASP_A_ERREN: rd_word = erren_ff;
                default: rd_word = 24'h00_0000;
            endcase
        end
    end

    // Frame state; select tied low still frames by bit count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ASP_ST_CMD;
            cnt_ff <= 5'h00;
        end else if (lk.soft_rst || !lk.cs_act) begin
            st_ff <= ASP_ST_CMD;
            cnt_ff <= 5'h00;
        end else if (cmd_done) begin
            cnt_ff <= 5'h00;
            if (nxt_cmd[`ASP_CMD_WEN]) begin
                st_ff <= ASP_ST_CMD;
            end else if (nxt_cmd[`ASP_CMD_RD]) begin
                st_ff <= ASP_ST_RD;
            end else begin
                st_ff <= ASP_ST_WR;
            end
        end else if (last_bit) begin
            st_ff <= ASP_ST_CMD;
            cnt_ff <= 5'h00;
        end else if (lk.rise) begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end

    // Command shift register, address and phase length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ff <= 8'h00;
            addr_ff <= 6'h00;
            len_ff <= `ASP_LEN8;
        end else if (lk.rise && st_ff == ASP_ST_CMD) begin
            cmd_ff <= nxt_cmd;
            if (cmd_done) begin
                addr_ff <= nxt_cmd[5:0];
                len_ff <= cmd_len;
            end
        end
    end

    // Write shifter; read shifter loads left aligned at command end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_sh_ff <= 24'h00_0000;
            rd_sh_ff <= 32'h0000_0000;
        end else if (cmd_done) begin
            wr_sh_ff <= 24'h00_0000;
            rd_sh_ff <= {rd_word, 8'h00} << 5'(`ASP_LEN24 - cmd_len);
        end else begin
            if (lk.rise && st_ff == ASP_ST_WR) begin
                wr_sh_ff <= nxt_wr;
            end
            if (lk.fall && st_ff == ASP_ST_RD) begin
                rd_sh_ff <= {rd_sh_ff[30:0], 1'b0};
            end
        end
    end

    // Output bit changes only on a falling edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_ff <= 1'b0;
            dout_oe_ff <= 1'b0;
        end else begin
            dout_oe_ff <= lk.cs_act;
            if (lk.fall) begin
                dout_ff <= (st_ff == ASP_ST_RD) ? rd_sh_ff[31] : 1'b0;
            end
        end
    end

    // Register file; both resets restore defaults
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `ASP_NCH; i++) begin
                ch_ff[i] <= (i == 0) ? `ASP_RST_CH0 : `ASP_RST_CH;
            end
            for (int i = 0; i < `ASP_NCFG; i++) begin
                cfg_ff[i] <= `ASP_RST_CFG;
            end
            ctrl_ff <= `ASP_RST_CTRL;
            io_ff <= `ASP_RST_IO;
            erren_ff <= `ASP_RST_ERREN;
        end else if (lk.soft_rst) begin
            for (int i = 0; i < `ASP_NCH; i++) begin
                ch_ff[i] <= (i == 0) ? `ASP_RST_CH0 : `ASP_RST_CH;
            end
            for (int i = 0; i < `ASP_NCFG; i++) begin
                cfg_ff[i] <= `ASP_RST_CFG;
            end
            ctrl_ff <= `ASP_RST_CTRL;
            io_ff <= `ASP_RST_IO;
            erren_ff <= `ASP_RST_ERREN;
        end else if (last_bit && st_ff == ASP_ST_WR && lk.cs_act) begin
            // Commit only a full phase; aborted writes leave no trace
            if (in_blk(addr_ff, `ASP_A_CH0, `ASP_NCH)) begin
                ch_ff[4'(addr_ff - `ASP_A_CH0)] <= nxt_wr[15:0];
            end else if (in_blk(addr_ff, `ASP_A_CFG0, `ASP_NCFG)) begin
                cfg_ff[3'(addr_ff - `ASP_A_CFG0)] <= nxt_wr[15:0];
            end else if (addr_ff == `ASP_A_CTRL) begin
                ctrl_ff <= nxt_wr[15:0];
            end else if (addr_ff == `ASP_A_IO) begin
                io_ff <= nxt_wr;
            end else if (addr_ff == `ASP_A_ERREN) begin
                erren_ff <= nxt_wr;
            end
        end
    end

    // Conversion slot timer; steps sequencer in continuous mode only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= 32'h0000_0000;
        end else if (lk.soft_rst || tick_ff == 32'(CONV_CYCLES - 1)) begin
            tick_ff <= 32'h0000_0000;
        end else begin
            tick_ff <= tick_ff + 32'h0000_0001;
        end
    end

    always_comb begin
        for (int i = 0; i < `ASP_NCH; i++) begin
            en_mask[i] = ch_ff[i][`ASP_CH_EN];
        end
    end
    assign seq_step = tick_ff == 32'(CONV_CYCLES - 1)
        && ctrl_ff[`ASP_MODE_LSB +: 4] == `ASP_MODE_CONT;

    asp_sequencer #(
        .NCH(`ASP_NCH)
    ) u_seq (
        .clk(clk),
        .rst_n(rst_n),
        .srst(lk.soft_rst),
        .step(seq_step),
        .mask(en_mask),
        .chan_ff(active_chan)
    );

    assign dout = dout_ff;
    assign dout_oe = dout_oe_ff;
    assign gpio = io_ff[3:0];

    // Sequences for a completed read or write command byte
    sequence cmd_read_s;
        cmd_done && !nxt_cmd[`ASP_CMD_WEN] && nxt_cmd[`ASP_CMD_RD];
    endsequence
    sequence cmd_write_s;
        cmd_done && nxt_cmd[7:6] == 2'b00;
    endsequence

    cs_abort_a: assert property (
        !lk.cs_act |=> st_ff == ASP_ST_CMD && cnt_ff == 5'h00)
        else $error("raised select did not abort the frame");
    wen_block_a: assert property (
        cmd_done && nxt_cmd[`ASP_CMD_WEN] && lk.cs_act && !lk.soft_rst
        |=> st_ff == ASP_ST_CMD)
        else $error("command with bit 7 set was accepted");
    read_dir_a: assert property (
        cmd_read_s and (lk.cs_act && !lk.soft_rst) |=> st_ff == ASP_ST_RD)
        else $error("read command did not start a read phase");
    id_read_a: assert property (
        cmd_read_s and (nxt_cmd[5:0] == `ASP_A_ID && !lk.soft_rst)
        |=> rd_sh_ff[31:24] == PART_ID)
        else $error("identity read loaded the wrong value");
    phase_end_a: assert property (
        last_bit && lk.cs_act && !lk.soft_rst |=> st_ff == ASP_ST_CMD)
        else $error("data phase did not return to command state");
    dout_edge_a: assert property (
        !lk.fall |=> $stable(dout_ff))
        else $error("output bit changed off a falling edge");
    soft_reset_a: assert property (
        lk.soft_rst |=> ctrl_ff == `ASP_RST_CTRL && io_ff == `ASP_RST_IO)
        else $error("device reset left registers changed");
    wr_len_a: assert property (
        cmd_write_s and (nxt_cmd[5:0] == `ASP_A_IO && !lk.soft_rst)
        |=> len_ff == `ASP_LEN24)
        else $error("write phase length wrong for address");

    // Commit of a full write phase while select still stands
    sequence wr_commit_s;
        last_bit && st_ff == ASP_ST_WR && lk.cs_act && !lk.soft_rst;
    endsequence

    write_dir_a: assert property (
        cmd_write_s and (lk.cs_act && !lk.soft_rst) |=> st_ff == ASP_ST_WR)
        else $error("write command did not start a write phase");
    addr_latch_a: assert property (
        cmd_done |=> addr_ff == $past(nxt_cmd[5:0]))
        else $error("command address was not latched");
    bit_count_a: assert property (
        cmd_done && lk.cs_act && !lk.soft_rst |=> cnt_ff == 5'h00)
        else $error("bit count did not restart after the command");
    status_read_a: assert property (
        cmd_read_s and (nxt_cmd[5:0] == `ASP_A_STATUS && !lk.soft_rst)
        |=> rd_sh_ff[31:24] == {4'h0, $past(active_chan)})
        else $error("status read did not load the channel");
    io_commit_a: assert property (
        wr_commit_s and (addr_ff == `ASP_A_IO) |=> io_ff == $past(nxt_wr))
        else $error("output register write was lost");
    id_fixed_a: assert property (
        wr_commit_s and (addr_ff == `ASP_A_ID)
        |=> $stable(ctrl_ff) && $stable(io_ff) && $stable(erren_ff))
        else $error("identity write changed a register");
    abort_keep_a: assert property (
        !lk.cs_act && !lk.soft_rst |=> $stable(io_ff) && $stable(ctrl_ff))
        else $error("raised select changed register contents");
    ch_default_a: assert property (
        lk.soft_rst |=> ch_ff[0] == `ASP_RST_CH0 && ch_ff[1] == `ASP_RST_CH)
        else $error("device reset left channel defaults wrong");
    cfg_default_a: assert property (
        lk.soft_rst |=> cfg_ff[0] == `ASP_RST_CFG)
        else $error("device reset left setup defaults wrong");
    diag_default_a: assert property (
        lk.soft_rst |=> erren_ff == `ASP_RST_ERREN)
        else $error("device reset left diagnostics wrong");
    seq_hold_a: assert property (
        !seq_step && !lk.soft_rst |=> $stable(active_chan))
        else $error("sequencer moved without a slot step");
endmodule

/* test/adc_serial_register_port_tb.sv */
// Self-checking bench for the serial register port
`timescale 1ns/1ps
module adc_serial_register_port_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, cs_n, din, dout, dout_oe;
    logic [3:0] gpio, active_chan;
    int fail_count = 0;
    int compares = 0;
    logic [31:0] r;
    logic oe;
    logic [3:0] prev;
    logic [15:0] mask;
    int seen;

    // 50 MHz system clock
    always #10 clk = ~clk;

    // Short conversion slots keep the sequencer run brief
    asp_serial_port #(.CONV_CYCLES(16)) i_dut (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe), .gpio(gpio),
        .active_chan(active_chan)
    );

    asp_host_model u_host (
        .clk(clk), .dout(dout), .dout_oe(dout_oe),
        .sclk(sclk), .cs_n(cs_n), .din(din)
    );

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Write: command byte with bit 7 and bit 6 clear, then data
    task automatic wr(input logic [5:0] a, input int n,
                      input logic [31:0] d);
        u_host.select();
        u_host.shift({24'h00_0000, 2'b00, a}, 8, r, oe);
        u_host.shift(d, n, r, oe);
        u_host.deselect();
    endtask

    // Read: command byte with bit 6 set, then n bits from the device
    task automatic rd(input logic [5:0] a, input int n,
                      input logic [31:0] exp, input string name);
        u_host.select();
        u_host.shift({24'h00_0000, 2'b01, a}, 8, r, oe);
        u_host.shift(32'h0000_0000, n, r, oe);
        u_host.deselect();
        check(name, exp, r);
        check("dout_oe", 32'h0000_0001, {31'h0, oe});
    endtask

    // Next enabled channel after cur, ascending with wrap
    function automatic logic [3:0] next_chan(input logic [3:0] cur);
        logic [3:0] idx;
        next_chan = cur;
        for (int k = 16; k >= 1; k--) begin
            idx = cur + k[3:0];
            if (mask[idx])
                next_chan = idx;
        end
    endfunction

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Identity and power-on defaults, command first
        rd(6'h05, 8, 32'h0000_0030, "part_identity");
        rd(6'h09, 16, 32'h0000_8001, "chan0");
        rd(6'h0B, 16, 32'h0000_0001, "chan2");
        rd(6'h19, 16, 32'h0000_0800, "setup0");
        rd(6'h20, 16, 32'h0000_0800, "setup7");
        rd(6'h01, 16, 32'h0000_0000, "control");
        rd(6'h07, 24, 32'h0000_0040, "diag_enable");
        // Write then read back a channel and the output register
        wr(6'h0A, 16, 32'h0000_8021);
        rd(6'h0A, 16, 32'h0000_8021, "chan1");
        wr(6'h03, 24, 32'h0000_000A);
        check("gpio", 32'h0000_000A, {28'h0, gpio});
        rd(6'h03, 24, 32'h0000_000A, "io_reg");
        // Identity write dropped; refused command, then a fresh one
        wr(6'h05, 8, 32'h0000_00FF);
        u_host.select();
        u_host.shift(32'h0000_0080, 8, r, oe);
        u_host.shift(32'h0000_0045, 8, r, oe);
        u_host.shift(32'h0000_0000, 8, r, oe);
        u_host.deselect();
        check("id_after_refused", 32'h0000_0030, r);
        // Abort a write half way; contents stay untouched
        u_host.select();
        u_host.shift(32'h0000_000B, 8, r, oe);
        u_host.shift(32'h0000_0055, 8, r, oe);
        u_host.deselect();
        rd(6'h0B, 16, 32'h0000_0001, "chan2_aborted");
        rd(6'h0A, 16, 32'h0000_8021, "chan1_kept");
        // Select held low across two back-to-back reads
        u_host.select();
        u_host.shift(32'h0000_0045, 8, r, oe);
        u_host.shift(32'h0000_0000, 8, r, oe);
        check("id_three_wire", 32'h0000_0030, r);
        u_host.shift(32'h0000_004A, 8, r, oe);
        u_host.shift(32'h0000_0000, 16, r, oe);
        u_host.deselect();
        check("chan1_three_wire", 32'h0000_8021, r);
        // Sequencer with channels 0, 1 and 3 enabled
        wr(6'h0C, 16, 32'h0000_8001);
        mask = 16'h000B;
        seen = 0;
        prev = active_chan;
        for (int t = 0; t < 2000 && seen < 6; t++) begin
            @(negedge clk);
            if (active_chan !== prev) begin
                check("active_chan", {28'h0, next_chan(prev)},
                      {28'h0, active_chan});
                prev = active_chan;
                seen++;
            end
        end
        check("sequencer_steps", 32'd6, seen);
        // A non-continuous mode code holds the sequencer still
        wr(6'h01, 16, 32'h0000_0004);
        prev = active_chan;
        repeat (64) @(posedge clk);
        check("chan_held", {28'h0, prev}, {28'h0, active_chan});
        // 64 ones in a row reset every register
        u_host.select();
        u_host.shift(32'hFFFF_FFFF, 32, r, oe);
        u_host.shift(32'hFFFF_FFFF, 32, r, oe);
        u_host.deselect();
        rd(6'h0A, 16, 32'h0000_0001, "chan1_after_ones");
        check("gpio_after_ones", 32'h0000_0000, {28'h0, gpio});
        rd(6'h05, 8, 32'h0000_0030, "id_after_ones");
        // Address zero reads status, never the command byte
        rd(6'h00, 8, 32'h0000_0000, "status");
        check("chan_reset", 32'h0000_0000, {28'h0, active_chan});
        complete_run();
    end
endmodule

/* test/asp_host_model.sv */
// Host side of the serial link: a mode 3 master driven by tasks
`timescale 1ns/1ps
module asp_host_model (
    input wire logic clk,
    input wire logic dout,
    input wire logic dout_oe,
    output logic sclk,
    output logic cs_n,
    output logic din
);
    // Link idles with clock high and select released
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b1;
    end

    // Select, then leave the synchroniser time before the first edge
    task automatic select();
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Release select; data line flips so a stale level is never trusted
    task automatic deselect();
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        din <= ~din;
        repeat (4) @(posedge clk);
    endtask

    // Shift n bits MSB first: drive on fall, sample on rise, 160 ns period
    task automatic shift(input logic [31:0] tx, input int n,
                         output logic [31:0] rx, output logic oe_seen);
        rx = '0;
        oe_seen = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            sclk <= 1'b0;
            din <= tx[i];
            repeat (3) @(posedge clk);
            // Sample away from the edge the device updates on
            @(negedge clk);
            // Undriven line reads as the inverse, so it cannot pass
            rx = {rx[30:0], dout_oe ? dout : ~dout};
            oe_seen = oe_seen & dout_oe;
            @(posedge clk);
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule
